// ===== core/swe_defines.svh
/*
  Constants of the serial word memory link: array shape, mode codes, timing.
  Assumes a 50 MHz reference clock and a controller-made link clock near 14 kHz.
*/
`ifndef SWE_DEFINES_SVH
`define SWE_DEFINES_SVH

// ----------------------------------------------------------------
// Array shape
// ----------------------------------------------------------------
`define SWE_WORDS        100
`define SWE_WIDTH        14
`define SWE_RADIX        10
`define SWE_DIGIT_W      10
`define SWE_ADDR_W       20
`define SWE_IDX_W        7

// ----------------------------------------------------------------
// Mode codes, {select 1, select 2, select 3}
// ----------------------------------------------------------------
`define SWE_MODE_STANDBY 3'h7
`define SWE_MODE_UNUSED  3'h6
`define SWE_MODE_ERASE   3'h5
`define SWE_MODE_ADDR    3'h4
`define SWE_MODE_READ    3'h3
`define SWE_MODE_SHOUT   3'h2
`define SWE_MODE_WRITE   3'h1
`define SWE_MODE_DATA    3'h0

// Pins idle high: link clock high, standby, line pulled up
`define SWE_SYNC_RST     5'h1F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SWE_REF_HZ       50000000
`define SWE_LINK_HZ      14000
`define SWE_HALF_CYC     (`SWE_REF_HZ / (2 * `SWE_LINK_HZ))
`define SWE_HOLD_MS      20
`define SWE_HOLD_CYC     (`SWE_REF_HZ / 1000 * `SWE_HOLD_MS)
`define SWE_ACCESS_US    20
`define SWE_ACCESS_CYC   (`SWE_REF_HZ / 1000000 * `SWE_ACCESS_US)

`endif

// ===== core/swe_pkg.sv
/*
  Types and digit coding shared by both ends of the link.
  Assumes swe_defines.svh is on the include path.
*/
`include "swe_defines.svh"
package swe_pkg;

  typedef enum logic {swe_op_read, swe_op_write} swe_op_t;

  typedef enum logic [2:0] {
    st_idle, st_addr, st_erase, st_data, st_write, st_read, st_shout
  } swe_hstate_t;

  // One-of-ten code of a decimal digit; zero for values above nine
  function automatic logic [`SWE_DIGIT_W-1:0] swe_digit_enc(input logic [3:0] v);
    logic [`SWE_DIGIT_W-1:0] r;
    r = '0;
    for (int i = 0; i < `SWE_RADIX; i++) begin
      if (v == 4'(i)) r[i] = 1'h1;
    end
    return r;
  endfunction

  // Returns {valid, digit}; valid only when exactly one bit is set
  function automatic logic [4:0] swe_digit_dec(input logic [`SWE_DIGIT_W-1:0] d);
    logic [3:0] val;
    logic [3:0] ones;
    val  = 4'h0;
    ones = 4'h0;
    for (int i = 0; i < `SWE_RADIX; i++) begin
      if (d[i]) begin
        val  = 4'(i);
        ones = ones + 4'h1;
      end
    end
    return {(ones == 4'h1), val};
  endfunction

endpackage

// ===== core/swe_if.sv
/*
  Link between controller and memory: clock, three mode selects, shared data line.
  Assumes at most one end enables its driver; an undriven line reads high.
*/
`timescale 1ns/10ps
interface swe_if;
  logic link_clk;
  logic mode_select_bit_1;
  logic mode_select_bit_2;
  logic mode_select_bit_3;
  logic host_dat;
  logic host_oe;
  logic dev_dat;
  logic dev_oe;
  logic line;

  assign line = dev_oe ? dev_dat : (host_oe ? host_dat : 1'h1);

  modport dev (
    input  link_clk, mode_select_bit_1, mode_select_bit_2, mode_select_bit_3, line,
    output dev_dat, dev_oe
  );
  modport host (
    output link_clk, mode_select_bit_1, mode_select_bit_2, mode_select_bit_3,
    output host_dat, host_oe,
    input  line
  );
endinterface // swe_if

// ===== core/swe_device.sv
/*
  Memory end of the link: mode decode, address and data shift registers,
  and a 100 x 14 word array.
  Assumes the controller makes the link clock and changes selects and data
  only while that clock is high; all link pins are asynchronous here.
*/
`timescale 1ns/10ps
`include "swe_defines.svh"
module swe_device #(
  parameter int WORDS = `SWE_WORDS,
  parameter int WIDTH = `SWE_WIDTH
) (
  input  logic       ref_clk_i,
  input  logic       rst_n_i,
  swe_if.dev         link,
  output logic [2:0] mode_o,
  output logic       addr_valid_o
);

  localparam int AW = `SWE_ADDR_W;
  localparam int DW = `SWE_DIGIT_W;
  localparam int IW = `SWE_IDX_W;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins;
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic       sclk;
  logic [2:0] smode;
  logic       sdat;

  always_comb begin
    pins = {link.link_clk, link.mode_select_bit_1, link.mode_select_bit_2,
            link.mode_select_bit_3, link.line};
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= `SWE_SYNC_RST;
      sync_q <= `SWE_SYNC_RST;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  always_comb begin
    sclk  = sync_q[4];
    smode = sync_q[3:1];
    sdat  = sync_q[0];
  end

  // ----------------------------------------------------------------
  // Mode acceptance and link clock edges
  // ----------------------------------------------------------------
  // A code is taken only after two equal samples: the three selects can
  // resolve apart in the synchronisers, and a passing code such as write
  // would otherwise damage a word.
  logic [2:0] cand_q;
  logic [2:0] cand_d;
  logic [2:0] mode_q;
  logic [2:0] mode_d;
  logic [2:0] act_prev_q;
  logic [2:0] act_prev_d;
  logic       clk_prev_q;
  logic       clk_prev_d;
  logic       rise;
  logic       fall;
  logic       entry;

  always_comb begin
    cand_d     = smode;
    mode_d     = (smode == cand_q) ? smode : mode_q;
    act_prev_d = mode_q;
    clk_prev_d = sclk;
    rise       = sclk & ~clk_prev_q;
    fall       = ~sclk & clk_prev_q;
    entry      = (mode_q != act_prev_q);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cand_q     <= `SWE_MODE_STANDBY;
      mode_q     <= `SWE_MODE_STANDBY;
      act_prev_q <= `SWE_MODE_STANDBY;
      clk_prev_q <= 1'h1;
    end else begin
      cand_q     <= cand_d;
      mode_q     <= mode_d;
      act_prev_q <= act_prev_d;
      clk_prev_q <= clk_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [AW-1:0] addr_q;
  logic [AW-1:0] addr_d;
  logic [4:0]    tens_dec;
  logic [4:0]    units_dec;
  logic          hit;
  logic [IW-1:0] idx;

  always_comb begin
    tens_dec  = swe_pkg::swe_digit_dec(addr_q[AW-1 -: DW]);
    units_dec = swe_pkg::swe_digit_dec(addr_q[DW-1:0]);
    hit       = tens_dec[4] & units_dec[4];
    idx       = IW'(tens_dec[3:0]) * IW'(`SWE_RADIX) + IW'(units_dec[3:0]);
  end

  // ----------------------------------------------------------------
  // Word array and shift registers
  // ----------------------------------------------------------------
  // Write only adds ones, like the charge-trapping cell it stands for, so
  // a word must be erased first to take a new value. A bad address
  // (not one bit per digit) is ignored by erase and write, reads as zero.
  logic [WIDTH-1:0] mem_q [WORDS];
  logic [WIDTH-1:0] mem_d [WORDS];
  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] data_d;
  logic             dat_q;
  logic             dat_d;
  logic             oe_q;
  logic             oe_d;
  logic             valid_q;
  logic             valid_d;

  always_comb begin
    addr_d  = addr_q;
    data_d  = data_q;
    mem_d   = mem_q;
    oe_d    = 1'h0;
    valid_d = hit;
    case (mode_q)
      `SWE_MODE_ADDR: begin
        if (fall) addr_d = {addr_q[AW-2:0], sdat};
      end
      `SWE_MODE_DATA: begin
        if (fall) data_d = {data_q[WIDTH-2:0], sdat};
      end
      `SWE_MODE_READ: begin
        if (entry) data_d = hit ? mem_q[idx] : '0;
      end
      `SWE_MODE_SHOUT: begin
        oe_d = 1'h1;
        // Entry shows the top bit; each later rise brings the next one.
        // Rotation keeps the word, so it can be shifted out again.
        if (rise && !entry) begin
          data_d = {data_q[WIDTH-2:0], data_q[WIDTH-1]};
        end
      end
      `SWE_MODE_ERASE: begin
        if (entry && hit) mem_d[idx] = '0;
      end
      `SWE_MODE_WRITE: begin
        if (entry && hit) mem_d[idx] = mem_q[idx] | data_q;
      end
      `SWE_MODE_UNUSED: begin
        // Same as standby
      end
      default: begin
        // Standby: all registers hold, line floats
      end
    endcase
    dat_d = data_d[WIDTH-1];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_q  <= '0;
      data_q  <= '0;
      dat_q   <= 1'h0;
      oe_q    <= 1'h0;
      valid_q <= 1'h0;
    end else begin
      addr_q  <= addr_d;
      data_q  <= data_d;
      dat_q   <= dat_d;
      oe_q    <= oe_d;
      valid_q <= valid_d;
    end
  end

  // Array is cleared at reset only so that simulation starts defined
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.dev_dat = dat_q;
  assign link.dev_oe  = oe_q;
  assign mode_o       = mode_q;
  assign addr_valid_o = valid_q;

endmodule // swe_device

// ===== core/swe_ctrl.sv
/*
  Controller end of the link: makes the link clock, drives the mode selects
  and sequences one read or one erase-then-write per request.
  Assumes the user holds request fields stable only in the cycle of req_i.
*/
`timescale 1ns/10ps
`include "swe_defines.svh"
module swe_ctrl #(
  parameter int WORDS    = `SWE_WORDS,
  parameter int WIDTH    = `SWE_WIDTH,
  parameter int HALF_CYC = `SWE_HALF_CYC,
  parameter int HOLD_CYC = `SWE_HOLD_CYC
) (
  input  logic                 ref_clk_i,
  input  logic                 rst_n_i,
  swe_if.host                  link,
  input  logic                 req_i,
  input  swe_pkg::swe_op_t     op_i,
  input  logic [`SWE_IDX_W-1:0] addr_i,
  input  logic [WIDTH-1:0]     wdata_i,
  output logic                 ready_o,
  output logic                 done_o,
  output logic [WIDTH-1:0]     rdata_o
);

  localparam int AW = `SWE_ADDR_W;
  localparam int IW = `SWE_IDX_W;
  localparam int VW = $clog2(HALF_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  swe_pkg::swe_hstate_t state_q, state_d;
  swe_pkg::swe_op_t     op_q, op_d;
  logic [VW-1:0]    div_q, div_d;
  logic [HW-1:0]    hold_q, hold_d;
  logic [4:0]       cnt_q, cnt_d;
  logic [AW-1:0]    sh_q, sh_d;
  logic [WIDTH-1:0] wbuf_q, wbuf_d;
  logic [WIDTH-1:0] rd_q, rd_d;
  logic [WIDTH-1:0] rdata_q, rdata_d;
  logic [2:0]       mode_q, mode_d;
  logic             lclk_q, lclk_d;
  logic             dat_q, dat_d;
  logic             oe_q, oe_d;
  logic             pend_q, pend_d;
  logic             ready_q, ready_d;
  logic             done_q, done_d;
  logic             meta_q, sdat_q;
  logic             tick, rise, fall, hold_done;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    tick      = (div_q == VW'(HALF_CYC - 1));
    rise      = tick & ~lclk_q;
    fall      = tick & lclk_q;
    hold_done = (hold_q == HW'(HOLD_CYC - 1));
    div_d     = tick ? '0 : div_q + VW'(1);
    lclk_d    = tick ? ~lclk_q : lclk_q;
    hold_d    = hold_done ? hold_q : hold_q + HW'(1);
    state_d = state_q;
    op_d    = op_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    wbuf_d  = wbuf_q;
    rd_d    = rd_q;
    rdata_d = rdata_q;
    mode_d  = mode_q;
    dat_d   = dat_q;
    oe_d    = oe_q;
    pend_d  = pend_q;
    ready_d = ready_q;
    done_d  = 1'h0;
    if (ready_q && req_i && (addr_i < IW'(WORDS))) begin
      pend_d  = 1'h1;
      ready_d = 1'h0;
      op_d    = op_i;
      wbuf_d  = wdata_i;
      sh_d    = {swe_pkg::swe_digit_enc(4'(addr_i / IW'(`SWE_RADIX))),
                 swe_pkg::swe_digit_enc(4'(addr_i % IW'(`SWE_RADIX)))};
    end
    if (fall && state_q == swe_pkg::st_shout) begin
      rd_d  = {rd_q[WIDTH-2:0], sdat_q};
      cnt_d = cnt_q + 5'h1;
    end
    // Selects and data move only on a rise, so they are stable while low
    if (rise) begin
      case (state_q)
        swe_pkg::st_idle: begin
          if (pend_q) begin
            state_d = swe_pkg::st_addr;
            pend_d  = 1'h0;
            mode_d  = `SWE_MODE_ADDR;
            oe_d    = 1'h1;
            dat_d   = sh_q[AW-1];
            sh_d    = {sh_q[AW-2:0], 1'h0};
            cnt_d   = 5'h0;
          end
        end
        swe_pkg::st_addr: begin
          if (cnt_q == 5'(AW - 1)) begin
            oe_d   = 1'h0;
            hold_d = '0;
            if (op_q == swe_pkg::swe_op_write) begin
              state_d = swe_pkg::st_erase;
              mode_d  = `SWE_MODE_ERASE;
            end else begin
              state_d = swe_pkg::st_read;
              mode_d  = `SWE_MODE_READ;
            end
          end else begin
            dat_d = sh_q[AW-1];
            sh_d  = {sh_q[AW-2:0], 1'h0};
            cnt_d = cnt_q + 5'h1;
          end
        end
        swe_pkg::st_erase: begin
          if (hold_done) begin
            state_d = swe_pkg::st_data;
            mode_d  = `SWE_MODE_DATA;
            oe_d    = 1'h1;
            dat_d   = wbuf_q[WIDTH-1];
            sh_d    = '0;
            sh_d[AW-1 -: WIDTH-1] = wbuf_q[WIDTH-2:0];
            cnt_d   = 5'h0;
          end
        end
        swe_pkg::st_data: begin
          if (cnt_q == 5'(WIDTH - 1)) begin
            state_d = swe_pkg::st_write;
            mode_d  = `SWE_MODE_WRITE;
            oe_d    = 1'h0;
            hold_d  = '0;
          end else begin
            dat_d = sh_q[AW-1];
            sh_d  = {sh_q[AW-2:0], 1'h0};
            cnt_d = cnt_q + 5'h1;
          end
        end
        swe_pkg::st_write: begin
          if (hold_done) begin
            state_d = swe_pkg::st_idle;
            mode_d  = `SWE_MODE_STANDBY;
            ready_d = 1'h1;
            done_d  = 1'h1;
          end
        end
        swe_pkg::st_read: begin
          state_d = swe_pkg::st_shout;
          mode_d  = `SWE_MODE_SHOUT;
          cnt_d   = 5'h0;
        end
        swe_pkg::st_shout: begin
          if (cnt_q == 5'(WIDTH)) begin
            state_d = swe_pkg::st_idle;
            mode_d  = `SWE_MODE_STANDBY;
            rdata_d = rd_q;
            ready_d = 1'h1;
            done_d  = 1'h1;
          end
        end
        default: begin
          state_d = swe_pkg::st_idle;
          mode_d  = `SWE_MODE_STANDBY;
          oe_d    = 1'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= swe_pkg::st_idle;
      op_q    <= swe_pkg::swe_op_read;
      div_q   <= '0;
      hold_q  <= '0;
      cnt_q   <= 5'h0;
      sh_q    <= '0;
      wbuf_q  <= '0;
      rd_q    <= '0;
      rdata_q <= '0;
      mode_q  <= `SWE_MODE_STANDBY;
      lclk_q  <= 1'h1;
      dat_q   <= 1'h0;
      oe_q    <= 1'h0;
      pend_q  <= 1'h0;
      ready_q <= 1'h1;
      done_q  <= 1'h0;
      meta_q  <= 1'h1;
      sdat_q  <= 1'h1;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      div_q   <= div_d;
      hold_q  <= hold_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      wbuf_q  <= wbuf_d;
      rd_q    <= rd_d;
      rdata_q <= rdata_d;
      mode_q  <= mode_d;
      lclk_q  <= lclk_d;
      dat_q   <= dat_d;
      oe_q    <= oe_d;
      pend_q  <= pend_d;
      ready_q <= ready_d;
      done_q  <= done_d;
      meta_q  <= link.line;
      sdat_q  <= meta_q;
    end
  end

  assign link.link_clk          = lclk_q;
  assign link.mode_select_bit_1 = mode_q[2];
  assign link.mode_select_bit_2 = mode_q[1];
  assign link.mode_select_bit_3 = mode_q[0];
  assign link.host_dat          = dat_q;
  assign link.host_oe           = oe_q;
  assign ready_o                = ready_q;
  assign done_o                 = done_q;
  assign rdata_o                = rdata_q;

endmodule // swe_ctrl

// ===== tb/swe_checker.sv
/*
  Concurrent checks on the link between the controller and the memory.
  Assumes link signals, ref clock and reset are wired in by name.
*/
`timescale 1ns/10ps
`include "swe_defines.svh"
module swe_checker #(
  parameter int HALF_CYC = `SWE_HALF_CYC,
  parameter int HOLD_CYC = `SWE_HOLD_CYC
) (
  input logic ref_clk_i,
  input logic rst_n_i,
  input logic link_clk,
  input logic mode_select_bit_1,
  input logic mode_select_bit_2,
  input logic mode_select_bit_3,
  input logic host_dat,
  input logic host_oe,
  input logic dev_dat,
  input logic dev_oe,
  input logic line
);
  localparam int ACC_CYC = `SWE_ACCESS_CYC;
  logic [2:0] code;
  logic [2:0] code_q;
  logic       lclk_q;
  logic [7:0] falls_q;
  logic [7:0] rise_q;
  logic [15:0] tog_q;
  int         run_q;

  assign code = {mode_select_bit_1, mode_select_bit_2, mode_select_bit_3};

  // --------
  // Helper counters
  // --------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_q  <= 3'h7;
      lclk_q  <= 1'h1;
      falls_q <= 8'h00;
      rise_q  <= 8'h00;
      tog_q   <= 16'h0000;
      run_q   <= 0;
    end else begin
      code_q <= code;
      lclk_q <= link_clk;
      tog_q  <= (link_clk != lclk_q) ? 16'h0000 : tog_q + 16'h0001;
      rise_q <= (link_clk && !lclk_q) ? 8'h00 : rise_q + 8'(rise_q != 8'hFF);
      // Fall count and run length restart when the code moves, so each frame is judged alone
      if (code != code_q) begin
        falls_q <= 8'h00;
        run_q   <= 0;
      end else begin
        run_q   <= run_q + 1;
        falls_q <= falls_q + 8'(lclk_q && !link_clk);
      end
    end
  end

  // --------
  // Properties
  // --------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_shout_entry;
    $changed(code) ##0 (code == 3'h2);
  endsequence

  property p_frame(logic [2:0] m, logic [7:0] n);
    (code != code_q && code_q == m) |-> falls_q == n;
  endproperty

  a_float_not_shout: assert property ((code != 3'h2)[*8] |-> !dev_oe)
    else $error("data line driven outside shift out");
  a_shout_drives: assert property ((code == 3'h2)[*8] |-> dev_oe)
    else $error("shift out without driver");
  a_first_bit: assert property (s_shout_entry |-> ##[1:ACC_CYC] dev_oe)
    else $error("first output bit late");
  a_bit_after_rise: assert property (dev_oe && $past(dev_oe) && $changed(dev_dat)
    |-> rise_q <= 8'h08)
    else $error("output bit not tied to rising clock");
  a_accept_driven: assert property ((code == 3'h4 || code == 3'h0) |-> host_oe && !dev_oe)
    else $error("accept mode line not driven by controller");
  a_no_contention: assert property (dev_oe |-> !host_oe)
    else $error("both ends drive the line");
  a_pins_on_high: assert property ($changed({code, host_dat, host_oe}) |-> link_clk)
    else $error("selects or data moved with clock low");
  a_clk_running: assert property (tog_q <= 16'(HALF_CYC + 1))
    else $error("link clock stalled");
  a_addr_frame: assert property (p_frame(3'h4, 8'h14))
    else $error("address frame not twenty bits");
  a_data_frame: assert property (p_frame(3'h0, 8'h0E))
    else $error("data frame not fourteen bits");
  a_out_frame: assert property (p_frame(3'h2, 8'h0E))
    else $error("output frame not fourteen bits");
  a_hold_time: assert property ((code != code_q && code_q inside {3'h5, 3'h1})
    |-> run_q >= HOLD_CYC - 2)
    else $error("erase or write held too short");
  a_erase_first: assert property ($changed(code) && code == 3'h0 |-> $past(code) == 3'h5)
    else $error("data accepted without erase");
endmodule // swe_checker

// ===== tb/serial_word_eeprom_mode_port_tb.sv
/*
  Top bench: controller and memory joined by the link, driven through the user port.
  Assumes the core files are compiled first and swe_defines.svh is on the path.
*/
`timescale 1ns/10ps
`include "swe_defines.svh"
module serial_word_eeprom_mode_port_tb;
  localparam int HALF = 8;
  localparam int HOLD = 50;
  logic                  ref_clk_i = 1'h0;
  logic                  rst_n_i = 1'h0;
  logic                  req_i = 1'h0;
  swe_pkg::swe_op_t      op_i = swe_pkg::swe_op_read;
  logic [`SWE_IDX_W-1:0] addr_i = '0;
  logic [13:0]           wdata_i = '0;
  logic                  ready_o;
  logic                  done_o;
  logic                  addr_valid_o;
  logic [13:0]           rdata_o;
  logic [2:0]            mode_o;
  logic [19:0]           addr_cap = '0;
  logic [13:0]           out_cap = '0;
  logic                  lclk_p = 1'h1;
  logic [2:0]            code;
  int                    failures = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  logic [6:0]            at [4] = '{7'h00, 7'h63, 7'h2D, 7'h09};
  logic [13:0]           dt [4] = '{14'h3FFF, 14'h2AAA, 14'h1555, 14'h2001};

  swe_if link_if ();
  swe_ctrl #(.HALF_CYC(HALF), .HOLD_CYC(HOLD)) swe_ctrl_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link_if.host), .req_i(req_i),
    .op_i(op_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
    .done_o(done_o), .rdata_o(rdata_o));
  swe_device swe_device_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link_if.dev), .mode_o(mode_o),
    .addr_valid_o(addr_valid_o));
  swe_checker #(.HALF_CYC(HALF), .HOLD_CYC(HOLD)) swe_checker_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_clk(link_if.link_clk),
    .mode_select_bit_1(link_if.mode_select_bit_1), .mode_select_bit_2(link_if.mode_select_bit_2),
    .mode_select_bit_3(link_if.mode_select_bit_3), .host_dat(link_if.host_dat),
    .host_oe(link_if.host_oe), .dev_dat(link_if.dev_dat), .dev_oe(link_if.dev_oe),
    .line(link_if.line));

  assign code = {link_if.mode_select_bit_1, link_if.mode_select_bit_2, link_if.mode_select_bit_3};

  always #10 ref_clk_i = ~ref_clk_i;

  // --------
  // Wire monitor and time limit
  // --------
  // Line is sampled at link falls, as the receiving end does
  always @(posedge ref_clk_i) begin
    lclk_p <= link_if.link_clk;
    cyc <= cyc + 1;
    if (lclk_p && !link_if.link_clk && code == 3'h4) addr_cap <= {addr_cap[18:0], link_if.line};
    if (lclk_p && !link_if.link_clk && code == 3'h2) out_cap <= {out_cap[12:0], link_if.line};
    if (cyc == 40000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  // --------
  // Tasks
  // --------
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run_op(input logic wr, input logic [6:0] a, input logic [13:0] d);
    int n;
    @(negedge ref_clk_i);
    req_i = 1'h1;
    op_i = swe_pkg::swe_op_t'(wr);
    addr_i = a;
    wdata_i = d;
    @(negedge ref_clk_i);
    req_i = 1'h0;
    n = 0;
    while (done_o !== 1'h1 && n < 4000) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(20'(n < 4000), 20'h00001);
  endtask

  task automatic read_chk(input logic [6:0] a, input logic [13:0] exp);
    int t;
    int u;
    t = a / 10;
    u = a % 10;
    run_op(1'h0, a, 14'h0000);
    check(20'(rdata_o), 20'(exp));
    check(20'(out_cap), 20'(exp));
    check(addr_cap, (20'h00001 << (10 + t)) | (20'h00001 << u));
    // The memory end takes a few cycles to accept standby and release the line
    repeat (6) @(negedge ref_clk_i);
    check(20'({addr_valid_o, mode_o, link_if.dev_oe}), 20'h0001E);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // --------
  // Tests
  // --------
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'h1;
    check(20'({ready_o, done_o, mode_o, addr_valid_o, link_if.dev_oe, link_if.line}), 20'h000B9);
    $display("test reset done");
    read_chk(7'h00, 14'h0000);
    $display("test fresh read done");
    for (int i = 0; i < 4; i++) begin
      run_op(1'h1, at[i], dt[i]);
    end
    for (int i = 0; i < 4; i++) begin
      read_chk(at[i], dt[i]);
    end
    $display("test write read done");
    // Write only sets bits, so a missed erase shows as 2BFF here
    run_op(1'h1, 7'h63, 14'h0155);
    read_chk(7'h63, 14'h0155);
    $display("test overwrite done");
    @(negedge ref_clk_i);
    req_i = 1'h1;
    addr_i = 7'h64;
    @(negedge ref_clk_i);
    req_i = 1'h0;
    repeat (3) @(negedge ref_clk_i);
    check(20'({ready_o, code}), 20'h0000F);
    $display("test refused address done");
    finish_test();
  end
endmodule // serial_word_eeprom_mode_port_tb
